/* rtl/dlc_host.sv */
// APB-controlled host that writes codes into a double-buffered converter latch.
// Assumes an APB master on pclk and the converter pins wired straight out.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dlc_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic op_select_0,
  output logic op_select_1,
  output logic [13:0] code_in,
  output logic factory_program_pin
);

  typedef struct packed {
    logic auto_load;
    logic direct;
    logic [13:0] code;
    logic pend;
    logic [1:0] pend_op;
    logic [1:0] step;
    logic refused;
    logic [7:0] low_sh;
    logic [5:0] high_sh;
    logic [13:0] conv_sh;
    logic [31:0] prdata;
  } dlc_host_type;

  dlc_host_type s_r, s_nxt;

  logic seq_start;
  logic seq_busy;
  logic seq_done;
  logic [1:0] seq_op;
  logic [13:0] seq_code;
  logic busy_any;
  logic setup_ph;
  logic wr_acc;
  logic mapped;

  // ---------------------------------------------------------------
  // Pin cycle engine
  // ---------------------------------------------------------------
  assign seq_start = s_r.pend && !seq_busy;

  dlc_pin_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .start(seq_start),
    .op_in(s_r.pend_op),
    .code_in(s_r.code),
    .busy(seq_busy),
    .done(seq_done),
    .cs_n(chip_select_n),
    .wr_n(write_strobe_n),
    .op(seq_op),
    .code(seq_code)
  );

  assign op_select_0 = seq_op[0];
  assign op_select_1 = seq_op[1];
  assign code_in = seq_code;
  assign factory_program_pin = 1'b1;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign busy_any = s_r.pend || seq_busy || (s_r.step != 2'h0);
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = s_r.prdata;

  always_comb begin
    unique case (paddr)
      dlc_pkg::REG_CTRL, dlc_pkg::REG_CMD, dlc_pkg::REG_CODE,
      dlc_pkg::REG_STATUS, dlc_pkg::REG_BUFS, dlc_pkg::REG_CONV: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Read data captured in the setup cycle
    if (setup_ph) begin
      s_nxt.prdata = 32'h0000_0000;
      unique case (paddr)
        dlc_pkg::REG_CTRL: begin
          s_nxt.prdata[dlc_pkg::CTRL_AUTO_BIT] = s_r.auto_load;
          s_nxt.prdata[dlc_pkg::CTRL_DIRECT_BIT] = s_r.direct;
        end
        dlc_pkg::REG_CODE: s_nxt.prdata[13:0] = s_r.code;
        dlc_pkg::REG_STATUS: begin
          s_nxt.prdata[dlc_pkg::ST_REFUSED_BIT] = s_r.refused;
          s_nxt.prdata[dlc_pkg::ST_BUSY_BIT] = busy_any;
        end
        dlc_pkg::REG_BUFS: begin
          s_nxt.prdata[7:0] = s_r.low_sh;
          s_nxt.prdata[dlc_pkg::BUFS_HIGH_LSB +: 6] = s_r.high_sh;
        end
        dlc_pkg::REG_CONV: s_nxt.prdata[13:0] = s_r.conv_sh;
        default: s_nxt.prdata = 32'h0000_0000;
      endcase
    end
    // Pending request handed to the engine
    if (seq_start) begin
      s_nxt.pend = 1'b0;
    end
    // Mirror of what the converter now holds
    if (seq_done) begin
      unique case (seq_op)
        dlc_pkg::OP_DIRECT: begin
          s_nxt.low_sh = seq_code[7:0];
          s_nxt.high_sh = seq_code[13:8];
          s_nxt.conv_sh = seq_code;
        end
        dlc_pkg::OP_LOW: s_nxt.low_sh = seq_code[7:0];
        dlc_pkg::OP_HIGH: s_nxt.high_sh = seq_code[13:8];
        dlc_pkg::OP_XFER: s_nxt.conv_sh = {s_r.high_sh, s_r.low_sh};
      endcase
      // Next step of a double-buffered load
      if (s_r.step != 2'h0) begin
        s_nxt.pend = 1'b1;
        s_nxt.pend_op = (s_r.step == 2'h2) ? dlc_pkg::OP_HIGH : dlc_pkg::OP_XFER;
        s_nxt.step = s_r.step - 2'h1;
      end
    end
    // Software writes
    if (wr_acc) begin
      unique case (paddr)
        dlc_pkg::REG_CTRL: begin
          s_nxt.auto_load = pwdata[dlc_pkg::CTRL_AUTO_BIT];
          s_nxt.direct = pwdata[dlc_pkg::CTRL_DIRECT_BIT];
        end
        dlc_pkg::REG_STATUS: begin
          if (pwdata[dlc_pkg::ST_REFUSED_BIT]) begin
            s_nxt.refused = 1'b0;
          end
        end
        dlc_pkg::REG_CODE: begin
          if (!busy_any) begin
            s_nxt.code = pwdata[13:0];
            if (s_r.auto_load) begin
              s_nxt.pend = 1'b1;
              s_nxt.pend_op = s_r.direct ? dlc_pkg::OP_DIRECT : dlc_pkg::OP_LOW;
              s_nxt.step = s_r.direct ? 2'h0 : 2'h2;
            end
          end
        end
        dlc_pkg::REG_CMD: begin
          if (!busy_any) begin
            s_nxt.pend = 1'b1;
            s_nxt.pend_op = pwdata[1:0];
            s_nxt.step = 2'h0;
          end
        end
        default: s_nxt.refused = s_r.refused;
      endcase
      // Set wins over a clear in the same cycle
      if (busy_any && ((paddr == dlc_pkg::REG_CODE) || (paddr == dlc_pkg::REG_CMD))) begin
        s_nxt.refused = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{auto_load: 1'b0, direct: 1'b0, code: 14'h0000, pend: 1'b0,
               pend_op: 2'h0, step: 2'h0, refused: 1'b0, low_sh: 8'h00,
               high_sh: 6'h00, conv_sh: 14'h0000, prdata: 32'h0000_0000};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_factory_program_pin_held_high: assert property (@(posedge pclk) disable iff (!presetn)
    factory_program_pin) else $error("program pin not held high");
  a_low_shadow: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_done && seq_op == dlc_pkg::OP_LOW) |=> s_r.low_sh == $past(seq_code[7:0]))
    else $error("low buffer mirror not updated");
  a_high_shadow: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_done && seq_op == dlc_pkg::OP_HIGH) |=> s_r.high_sh == $past(seq_code[13:8]))
    else $error("high buffer mirror not updated");
  a_double_load: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == dlc_pkg::REG_CODE && !busy_any && s_r.auto_load && !s_r.direct)
    |=> (s_r.pend_op == dlc_pkg::OP_LOW) ##[15:30] (s_r.conv_sh == s_r.code))
    else $error("double-buffered load did not complete");
  a_direct_load: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == dlc_pkg::REG_CODE && !busy_any && s_r.auto_load && s_r.direct)
    |=> ##[2:8] (op_select_0 == 1'b0 && op_select_1 == 1'b0 && !write_strobe_n
    && code_in == s_r.code)) else $error("direct load not issued");
  a_busy_refused: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && busy_any && paddr == dlc_pkg::REG_CMD) |=> s_r.refused && $stable(s_r.code))
    else $error("write while busy not refused");

  // ---------------------------------------------------------------
  // Pin cycle checks
  // ---------------------------------------------------------------
  a_idle_pins: assert property (@(posedge pclk) disable iff (!presetn)
    !busy_any |-> chip_select_n && write_strobe_n) else $error("strobes active while idle");
  a_launch_to_cs: assert property (@(posedge pclk) disable iff (!presetn)
    seq_start |=> !chip_select_n && write_strobe_n ##1 !write_strobe_n)
    else $error("pin cycle did not open with select then strobe");
  a_done_idle: assert property (@(posedge pclk) disable iff (!presetn)
    seq_done |-> chip_select_n && write_strobe_n && !seq_busy) else $error("cycle end with pins active");
  a_cs_gap: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(chip_select_n) |=> chip_select_n) else $error("no idle cycle between pin cycles");
  a_pins_held: assert property (@(posedge pclk) disable iff (!presetn)
    (!chip_select_n && $past(!chip_select_n)) |-> $stable(op_select_0) && $stable(op_select_1)
    && $stable(code_in)) else $error("select or data moved inside a pin cycle");
  a_code_on_pins: assert property (@(posedge pclk) disable iff (!presetn)
    !chip_select_n |-> code_in == s_r.code) else $error("data pins differ from code register");
  a_op_on_pins: assert property (@(posedge pclk) disable iff (!presetn)
    seq_start |=> !chip_select_n && {op_select_1, op_select_0} == $past(s_r.pend_op))
    else $error("select pins differ from requested operation");
  a_pend_consumed: assert property (@(posedge pclk) disable iff (!presetn)
    seq_start |=> !s_r.pend) else $error("request not consumed at launch");

  // ---------------------------------------------------------------
  // Sequencing checks
  // ---------------------------------------------------------------
  a_auto_low: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == dlc_pkg::REG_CODE && !busy_any && s_r.auto_load && !s_r.direct)
    |=> s_r.pend && s_r.step == 2'h2) else $error("buffered load not queued");
  a_auto_direct: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == dlc_pkg::REG_CODE && !busy_any && s_r.auto_load && s_r.direct)
    |=> s_r.pend && s_r.pend_op == dlc_pkg::OP_DIRECT && s_r.step == 2'h0)
    else $error("direct load not queued");
  a_cmd_launch: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == dlc_pkg::REG_CMD && !busy_any) |=> s_r.pend && s_r.pend_op == $past(pwdata[1:0]))
    else $error("command not queued");
  a_step_low: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_start && s_r.step == 2'h2) |-> s_r.pend_op == dlc_pkg::OP_LOW)
    else $error("first step is not a low load");
  a_step_high: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_start && s_r.step == 2'h1) |-> s_r.pend_op == dlc_pkg::OP_HIGH)
    else $error("second step is not a high load");
  a_xfer_last: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_done && seq_op == dlc_pkg::OP_HIGH && s_r.step == 2'h1)
    |=> s_r.pend && s_r.pend_op == dlc_pkg::OP_XFER && s_r.step == 2'h0) else $error("transfer not queued last");

  // ---------------------------------------------------------------
  // Mirror and status checks
  // ---------------------------------------------------------------
  a_xfer_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_done && seq_op == dlc_pkg::OP_XFER) |=> s_r.conv_sh == {$past(s_r.high_sh), $past(s_r.low_sh)})
    else $error("conversion mirror not loaded from buffers");
  a_direct_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_done && seq_op == dlc_pkg::OP_DIRECT) |=> s_r.conv_sh == $past(seq_code)
    && s_r.low_sh == $past(seq_code[7:0])) else $error("direct load mirror wrong");
  a_low_keeps_conv: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_done && seq_op == dlc_pkg::OP_LOW) |=> $stable(s_r.conv_sh) && $stable(s_r.high_sh))
    else $error("low load touched other registers");
  a_high_keeps_conv: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_done && seq_op == dlc_pkg::OP_HIGH) |=> $stable(s_r.conv_sh) && $stable(s_r.low_sh))
    else $error("high load touched other registers");
  a_conv_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !seq_done |=> $stable(s_r.conv_sh)) else $error("conversion mirror moved without a cycle end");
  a_bufs_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !seq_done |=> $stable(s_r.low_sh) && $stable(s_r.high_sh))
    else $error("buffer mirror moved without a cycle end");
  a_code_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    busy_any |=> $stable(s_r.code)) else $error("code register changed during a load");
  a_refused_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.refused && !(wr_acc && paddr == dlc_pkg::REG_STATUS && pwdata[dlc_pkg::ST_REFUSED_BIT]))
    |=> s_r.refused) else $error("refused flag lost");
  a_refused_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == dlc_pkg::REG_STATUS && pwdata[dlc_pkg::ST_REFUSED_BIT]) |=> !s_r.refused)
    else $error("refused flag not cleared");
  a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == dlc_pkg::REG_CTRL) |=> s_r.auto_load == $past(pwdata[dlc_pkg::CTRL_AUTO_BIT])
    && s_r.direct == $past(pwdata[dlc_pkg::CTRL_DIRECT_BIT])) else $error("control bits not taken");

  // ---------------------------------------------------------------
  // Read path checks
  // ---------------------------------------------------------------
  a_status_busy: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && paddr == dlc_pkg::REG_STATUS) |=> prdata[dlc_pkg::ST_BUSY_BIT] == $past(busy_any))
    else $error("busy bit read wrong");
  a_read_code: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && paddr == dlc_pkg::REG_CODE) |=> prdata == {18'h00000, $past(s_r.code)})
    else $error("code register read wrong");
  a_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !mapped) |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

endmodule // dlc_host
`default_nettype wire

/* rtl/dlc_pin_seq.sv */
// One write cycle on the converter pins: select, strobe, hold, release.
// Assumes start is only raised while busy is low.
`timescale 1ns/1ps
`default_nettype none
module dlc_pin_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [1:0] op_in,
  input wire logic [13:0] code_in,
  output logic busy,
  output logic done,
  output logic cs_n,
  output logic wr_n,
  output logic [1:0] op,
  output logic [13:0] code
);

  typedef struct packed {
    dlc_pkg::dlc_phase_type phase;
    logic [2:0] cnt;
    logic cs_n;
    logic wr_n;
    logic [1:0] op;
    logic [13:0] code;
    logic done;
  } dlc_seq_type;

  dlc_seq_type s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.phase)
      dlc_pkg::DLC_IDLE: begin
        if (start) begin
          s_nxt.phase = dlc_pkg::DLC_SETUP;
          s_nxt.cs_n = 1'b0;
          s_nxt.op = op_in;
          s_nxt.code = code_in;
          s_nxt.cnt = 3'(dlc_pkg::SETUP_CYC - 1);
        end
      end
      dlc_pkg::DLC_SETUP: begin
        if (s_r.cnt == 3'h0) begin
          s_nxt.phase = dlc_pkg::DLC_STROBE;
          s_nxt.wr_n = 1'b0;
          s_nxt.cnt = 3'(dlc_pkg::WR_CYC - 1);
        end else begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end
      end
      dlc_pkg::DLC_STROBE: begin
        if (s_r.cnt == 3'h0) begin
          s_nxt.phase = dlc_pkg::DLC_HOLD;
          s_nxt.wr_n = 1'b1;
          s_nxt.cnt = 3'(dlc_pkg::HOLD_CYC - 1);
        end else begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end
      end
      dlc_pkg::DLC_HOLD: begin
        if (s_r.cnt == 3'h0) begin
          s_nxt.phase = dlc_pkg::DLC_IDLE;
          s_nxt.cs_n = 1'b1;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{phase: dlc_pkg::DLC_IDLE, cnt: 3'h0, cs_n: 1'b1, wr_n: 1'b1,
               op: 2'h0, code: 14'h0000, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = (s_r.phase != dlc_pkg::DLC_IDLE);
  assign done = s_r.done;
  assign cs_n = s_r.cs_n;
  assign wr_n = s_r.wr_n;
  assign op = s_r.op;
  assign code = s_r.code;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_wr_inside_cs: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_n |-> !cs_n) else $error("write strobe low without chip select");
  a_wr_pulse_width: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(wr_n) |-> (!wr_n) [*2] ##1 wr_n) else $error("write pulse width wrong");
  a_addr_setup: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(wr_n) |-> $past(!cs_n) && $stable(op) && $stable(code))
    else $error("select or data not set up before strobe");
  a_hold_after_rise: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(wr_n) |-> !cs_n && $stable(op) && $stable(code) ##1 cs_n && done)
    else $error("no hold after strobe rise");
  a_cycle_bounded: assert property (@(posedge pclk) disable iff (!presetn)
    (start && !busy) |=> busy [*4] ##1 done) else $error("write cycle length wrong");

endmodule // dlc_pin_seq
`default_nettype wire

/* rtl/dlc_pkg.sv */
// Constants and types for the code latch host controller.
// Assumes a 10 MHz pclk and an external converter with a double-buffered latch.
package dlc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int ADDR_SETUP_NS = 100;
  localparam int WR_LOW_NS = 200;
  localparam int DATA_SETUP_NS = 200;
  localparam int HOLD_NS = 0;
  localparam int SETUP_RAW = (ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC = (SETUP_RAW > 0) ? SETUP_RAW : 1;
  localparam int WR_RAW = (WR_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_CYC = (WR_RAW > 0) ? WR_RAW : 1;
  localparam int HOLD_RAW = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (HOLD_RAW > 0) ? HOLD_RAW : 1;

  // ---------------------------------------------------------------
  // Widths and operation codes {op_select_1, op_select_0}
  // ---------------------------------------------------------------
  localparam int CODE_W = 14;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 6;
  localparam logic [1:0] OP_DIRECT = 2'h0;
  localparam logic [1:0] OP_LOW = 2'h2;
  localparam logic [1:0] OP_HIGH = 2'h1;
  localparam logic [1:0] OP_XFER = 2'h3;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_CODE = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_BUFS = 8'h10;
  localparam logic [7:0] REG_CONV = 8'h14;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_DIRECT_BIT = 1;
  localparam int ST_REFUSED_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int BUFS_HIGH_LSB = 8;

  typedef enum logic [1:0] {
    DLC_IDLE = 2'b00,
    DLC_SETUP = 2'b01,
    DLC_STROBE = 2'b10,
    DLC_HOLD = 2'b11
  } dlc_phase_type;

endpackage

/* testbench/dlc_conv_model.sv */
// Behavioural converter input latch: two code buffers and a conversion register.
// Assumes its strobes and data pins are driven by the host controller.
`timescale 1ns/1ps
`default_nettype none
module dlc_conv_model (
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic op_select_0,
  input wire logic op_select_1,
  input wire logic [13:0] code_in,
  output logic [7:0] low_buf,
  output logic [5:0] high_buf,
  output logic [13:0] conv
);
  // ---------------------------------------------------------------
  // Latch behaviour
  // ---------------------------------------------------------------
  logic [13:0] conv_r = 14'h0000;
  logic armed = 1'b0;
  logic act;
  logic [1:0] op;
  initial low_buf = 8'h00;
  initial high_buf = 6'h00;
  assign op = {op_select_1, op_select_0};
  assign act = !chip_select_n && !write_strobe_n;
  // Direct load is transparent while the write is active
  assign conv = (act && op == dlc_pkg::OP_DIRECT) ? code_in : conv_r;
  // Only a real low-to-high entry arms the latch
  always @(posedge act) armed = 1'b1;
  always @(negedge act) begin
    if (armed) begin
      case (op)
        dlc_pkg::OP_DIRECT: begin
          low_buf = code_in[7:0];
          high_buf = code_in[13:8];
          conv_r = code_in;
        end
        dlc_pkg::OP_LOW: low_buf = code_in[7:0];
        dlc_pkg::OP_HIGH: high_buf = code_in[13:8];
        default: conv_r = {high_buf, low_buf};
      endcase
    end
    armed = 1'b0;
  end
endmodule // dlc_conv_model
`default_nettype wire

/* testbench/dlc_host_tb.sv */
// Self-checking bench for the converter code latch host controller.
// Assumes dlc_host and the converter model wired pin to pin.
`timescale 1ns/1ps
`default_nettype none
module dlc_host_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, chip_select_n, write_strobe_n, op_select_0, op_select_1, factory_program_pin;
  logic [13:0] code_in;
  logic [13:0] conv;
  logic [7:0] low_buf;
  logic [5:0] high_buf;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  always #50 pclk = ~pclk;

  dlc_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n), .op_select_0(op_select_0),
    .op_select_1(op_select_1), .code_in(code_in), .factory_program_pin(factory_program_pin));
  dlc_conv_model u_conv (.chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .op_select_0(op_select_0), .op_select_1(op_select_1), .code_in(code_in),
    .low_buf(low_buf), .high_buf(high_buf), .conv(conv));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, dlc_pkg::REG_STATUS, 32'h0);
      if (rd[1] === 1'b0) break;
    end
  endtask

  task automatic wait_conv(input logic [13:0] exp);
    for (int i = 0; i < 100 && conv !== exp; i++) @(posedge pclk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    check("cs idle", chip_select_n, 1);
    check("wr idle", write_strobe_n, 1);
    check("factory_program_pin pin", factory_program_pin, 1);
    check("pready", pready, 1);
    apb(1'b0, dlc_pkg::REG_STATUS, 32'h0);
    check("status", rd, 0);
  endtask

  task automatic t_direct;
    apb(1'b1, dlc_pkg::REG_CODE, 32'h2a5c);
    apb(1'b1, dlc_pkg::REG_CMD, dlc_pkg::OP_DIRECT);
    wait_idle;
    check("conv direct", conv, 32'h2a5c);
    check("bufs direct", {high_buf, low_buf}, 32'h2a5c);
    apb(1'b0, dlc_pkg::REG_CONV, 32'h0);
    check("conv mirror", rd, 32'h2a5c);
  endtask

  task automatic t_double;
    apb(1'b1, dlc_pkg::REG_CODE, 32'h1234);
    apb(1'b1, dlc_pkg::REG_CMD, dlc_pkg::OP_LOW);
    wait_idle;
    check("low buf", low_buf, 32'h34);
    check("conv held", conv, 32'h2a5c);
    apb(1'b1, dlc_pkg::REG_CODE, 32'h3abc);
    apb(1'b0, dlc_pkg::REG_CODE, 32'h0);
    check("code readback", rd, 32'h3abc);
    check("mapped no err", err, 0);
    apb(1'b1, dlc_pkg::REG_CMD, dlc_pkg::OP_HIGH);
    wait_idle;
    check("high buf", high_buf, 32'h3a);
    check("low kept", low_buf, 32'h34);
    apb(1'b1, dlc_pkg::REG_CMD, dlc_pkg::OP_XFER);
    wait_idle;
    check("conv xfer", conv, 32'h3a34);
    apb(1'b0, dlc_pkg::REG_BUFS, 32'h0);
    check("bufs mirror", rd, 32'h3a34);
  endtask

  task automatic t_refuse;
    apb(1'b1, dlc_pkg::REG_CODE, 32'h0155);
    apb(1'b1, dlc_pkg::REG_CMD, dlc_pkg::OP_HIGH);
    apb(1'b1, dlc_pkg::REG_CMD, dlc_pkg::OP_LOW);
    apb(1'b0, dlc_pkg::REG_STATUS, 32'h0);
    check("refused", rd[0], 1);
    wait_idle;
    check("high only", high_buf, 32'h01);
    check("low untouched", low_buf, 32'h34);
    apb(1'b1, dlc_pkg::REG_STATUS, 32'h1);
    apb(1'b0, dlc_pkg::REG_STATUS, 32'h0);
    check("status clear", rd, 0);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped err", err, 1);
    check("unmapped data", rd, 0);
  endtask

  task automatic t_auto;
    apb(1'b1, dlc_pkg::REG_CTRL, 32'h1);
    apb(1'b1, dlc_pkg::REG_CODE, 32'h3fff);
    wait_conv(14'h3fff);
    check("auto conv", conv, 32'h3fff);
    wait_idle;
    apb(1'b1, dlc_pkg::REG_CTRL, 32'h3);
    apb(1'b0, dlc_pkg::REG_CTRL, 32'h0);
    check("ctrl readback", rd, 32'h3);
    apb(1'b1, dlc_pkg::REG_CODE, 32'h0001);
    wait_conv(14'h0001);
    check("auto direct", conv, 32'h0001);
    wait_idle;
    check("cs released", chip_select_n, 1);
    check("wr released", write_strobe_n, 1);
  endtask

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      complete_run;
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_direct;
    t_double;
    t_refuse;
    t_auto;
    complete_run;
  end
endmodule // dlc_host_tb
`default_nettype wire
